/* File: logic/swr_sleep_wake_reset.sv */
// sleep entry, wake-up, reset-cause flags and program/verify port of the core
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module swr_sleep_wake_reset #(
    parameter int WDOG_CYCLES = swr_pkg::WDOG_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [3:0] i_wake_pins,
    input wire logic [1:0] i_comparator_outputs,
    input wire logic i_master_clear_pin_n,
    input wire logic i_vpp_high,
    input wire logic i_code_protect,
    input wire logic [11:0] i_pmem_rdata,
    output logic o_device_reset,
    output logic o_osc_drive_en,
    output logic o_port_hold,
    output logic o_prog_mode,
    output logic o_prog_data_out,
    output logic o_prog_data_oe,
    output logic [10:0] o_pmem_addr,
    output logic [11:0] o_pmem_wdata,
    output logic o_pmem_we
);
    // ==========================================================
    // declarations
    localparam logic [19:0] WDOG_LAST = 20'(WDOG_CYCLES - 1);
    localparam logic [7:0] DRT_LAST = 8'(swr_pkg::DRT_CYC - 1);
    swr_pkg::swr_state_t state_reg, state_next;
    logic [7:0] sync1_reg, sync2_reg, prev_reg;
    logic [2:0] ctrl_reg;
    logic [3:0] port_snap_reg;
    logic [1:0] cmp_snap_reg;
    logic timeout_flag_n_reg, timeout_flag_n_next;
    logic powerdown_flag_n_reg, powerdown_flag_n_next;
    logic port_wake_flag_reg, port_wake_flag_next;
    logic comparator_wake_flag_reg, comparator_wake_flag_next;
    logic [19:0] watchdog_counter_reg;
    logic [7:0] drt_reg;
    logic osc_en_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic prog_reg, phase_reg, rd_dir_reg, dout_reg, oe_reg, we_reg;
    logic [4:0] bit_cnt_reg;
    logic [13:0] sh_reg;
    logic [10:0] addr_reg;
    logic [11:0] wdata_reg;
    logic [11:0] id_mem [4];

    function automatic logic at(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : at

    // ==========================================================
    // pin synchronisers: pins come from outside the clock domain
    wire [7:0] pin_vec = {i_vpp_high, i_master_clear_pin_n, i_comparator_outputs, i_wake_pins};
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            sync1_reg <= swr_pkg::SYNC_RESET;
            sync2_reg <= swr_pkg::SYNC_RESET;
            prev_reg <= swr_pkg::SYNC_RESET;
        end else begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // edge and level views, all from the second stage onward
    wire [3:0] wake_now = sync2_reg[3:0];
    wire [1:0] cmp_now = sync2_reg[5:4];
    wire mclear_low = ~sync2_reg[6];
    wire mclear_fall = prev_reg[6] & ~sync2_reg[6];
    wire vpp_rise = sync2_reg[7] & ~prev_reg[7];
    wire pclk_rise = sync2_reg[1] & ~prev_reg[1];
    wire pdat = sync2_reg[0];

    // ==========================================================
    // apb decode: one wait state so every answer comes from a flop
    wire apb_acc = i_psel & i_penable;
    wire apb_lat = apb_acc & ~pready_reg;
    wire apb_wr = apb_acc & pready_reg & i_pwrite;
    wire rd_lat = apb_lat & ~i_pwrite;
    wire hit_ctrl = at(i_paddr, swr_pkg::ADDR_CTRL);
    wire hit_cmd = at(i_paddr, swr_pkg::ADDR_CMD);
    wire hit_port = at(i_paddr, swr_pkg::ADDR_PORT);
    wire hit_cmp = at(i_paddr, swr_pkg::ADDR_CMP);
    wire hit_stat = at(i_paddr, swr_pkg::ADDR_STATUS);
    wire hit_state = at(i_paddr, swr_pkg::ADDR_STATE);
    wire mapped = hit_ctrl | hit_cmd | hit_port | hit_cmp | hit_stat | hit_state;
    wire [7:0] status_byte = {port_wake_flag_reg, comparator_wake_flag_reg, 1'b0,
                              timeout_flag_n_reg, powerdown_flag_n_reg, 3'h0};
    wire [31:0] rd_next = hit_stat ? {24'h0, status_byte} :
                          hit_ctrl ? {29'h0, ctrl_reg} :
                          hit_port ? {28'h0, wake_now} :
                          hit_cmp ? {30'h0, cmp_now} :
                          hit_state ? {29'h0, prog_reg, state_reg[1], state_reg[2]} : 32'h0;

    // ==========================================================
    // core requests and wake conditions
    wire asleep = state_reg == swr_pkg::SWR_SLEEP;
    wire running = state_reg == swr_pkg::SWR_RUN;
    wire sleep_go = apb_wr & hit_cmd & i_pwdata[swr_pkg::CMD_SLEEP] & running;
    wire clr_cmd = apb_wr & hit_cmd & i_pwdata[swr_pkg::CMD_CLR_WDOG];
    // a mismatch left over from before sleep wakes at once
    wire port_mis = ctrl_reg[swr_pkg::CTL_PORT_WEN] & (wake_now != port_snap_reg);
    wire cmp_mis = ctrl_reg[swr_pkg::CTL_CMP_WEN] & (cmp_now != cmp_snap_reg);
    wire ev_mclear = mclear_fall & ~prog_reg;
    wire ev_wdog = ctrl_reg[swr_pkg::CTL_WDOG_EN] & (watchdog_counter_reg == WDOG_LAST);
    wire ev_pin = asleep & port_mis;
    wire ev_cmp = asleep & cmp_mis;
    wire reset_trig = ev_mclear | ev_wdog | ev_pin | ev_cmp;
    wire hold_rst = mclear_low | prog_reg;

    // ==========================================================
    // control and snapshot registers; a read refreshes the snapshot it shows
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ctrl_reg <= swr_pkg::CTRL_RESET;
            port_snap_reg <= 4'h0;
            cmp_snap_reg <= 2'h0;
        end else begin
            if (apb_wr & hit_ctrl) begin
                ctrl_reg <= i_pwdata[2:0];
            end
            if (rd_lat & hit_port) begin
                port_snap_reg <= wake_now;
            end
            if (rd_lat & hit_cmp) begin
                cmp_snap_reg <= cmp_now;
            end
        end
    end

    // apb answer flops
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= apb_lat;
            pslverr_reg <= apb_lat & ~mapped;
            prdata_reg <= (rd_lat & mapped) ? rd_next : 32'h0;
        end
    end

    // ==========================================================
    // reset-cause flags, master clear beats watchdog beats pin beats comparator
    always_comb begin
        timeout_flag_n_next = timeout_flag_n_reg;
        powerdown_flag_n_next = powerdown_flag_n_reg;
        port_wake_flag_next = port_wake_flag_reg;
        comparator_wake_flag_next = comparator_wake_flag_reg;
        if (ev_mclear) begin
            port_wake_flag_next = 1'b0;
            comparator_wake_flag_next = 1'b0;
            if (asleep) begin
                timeout_flag_n_next = 1'b1;
                powerdown_flag_n_next = 1'b0;
            end
        end else if (ev_wdog) begin
            timeout_flag_n_next = 1'b0;
            port_wake_flag_next = 1'b0;
            comparator_wake_flag_next = 1'b0;
            if (asleep) begin
                powerdown_flag_n_next = 1'b0;
            end
        end else if (ev_pin) begin
            port_wake_flag_next = 1'b1;
            comparator_wake_flag_next = 1'b0;
            timeout_flag_n_next = 1'b1;
            powerdown_flag_n_next = 1'b0;
        end else if (ev_cmp) begin
            comparator_wake_flag_next = 1'b1;
            port_wake_flag_next = 1'b0;
            timeout_flag_n_next = 1'b1;
            powerdown_flag_n_next = 1'b0;
        end else if (sleep_go) begin
            timeout_flag_n_next = 1'b1;
            powerdown_flag_n_next = 1'b0;
        end
    end

    // only power-up loads their reset values, never the generated reset
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            timeout_flag_n_reg <= 1'b1;
            powerdown_flag_n_reg <= 1'b1;
            port_wake_flag_reg <= 1'b0;
            comparator_wake_flag_reg <= 1'b0;
        end else begin
            timeout_flag_n_reg <= timeout_flag_n_next;
            powerdown_flag_n_reg <= powerdown_flag_n_next;
            port_wake_flag_reg <= port_wake_flag_next;
            comparator_wake_flag_reg <= comparator_wake_flag_next;
        end
    end

    // ==========================================================
    // run / sleep / reset sequencing
    always_comb begin
        case (state_reg)
            swr_pkg::SWR_RUN: begin
                if (reset_trig | prog_reg) begin
                    state_next = swr_pkg::SWR_RST;
                end else if (sleep_go) begin
                    state_next = swr_pkg::SWR_SLEEP;
                end else begin
                    state_next = swr_pkg::SWR_RUN;
                end
            end
            swr_pkg::SWR_SLEEP: begin
                state_next = (reset_trig | prog_reg) ? swr_pkg::SWR_RST : swr_pkg::SWR_SLEEP;
            end
            swr_pkg::SWR_RST: begin
                state_next = (drt_reg == 8'h0 && !hold_rst) ? swr_pkg::SWR_RUN : swr_pkg::SWR_RST;
            end
            default: begin
                state_next = swr_pkg::SWR_RST;
            end
        endcase
    end

    // reset is internal only: nothing here can pull the master clear pin
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg <= swr_pkg::SWR_RST;
            drt_reg <= DRT_LAST;
            osc_en_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            osc_en_reg <= state_next != swr_pkg::SWR_SLEEP;
            if (reset_trig | hold_rst) begin
                drt_reg <= DRT_LAST;
            end else if (drt_reg != 8'h0) begin
                drt_reg <= drt_reg - 8'h1;
            end
        end
    end

    // ==========================================================
    // watchdog: free of the sleep state, so it keeps counting asleep
    wire wdog_clr = sleep_go | clr_cmd | (asleep & reset_trig) | state_reg[2];
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            watchdog_counter_reg <= 20'h0;
        end else if (wdog_clr | ev_wdog | ~ctrl_reg[swr_pkg::CTL_WDOG_EN]) begin
            watchdog_counter_reg <= 20'h0;
        end else begin
            watchdog_counter_reg <= watchdog_counter_reg + 20'h1;
        end
    end

    // ==========================================================
    // program/verify: 6 command bits then 14 framed data bits, lsb first
    wire id_hit = addr_reg[10:2] == swr_pkg::ID_BASE[10:2];
    wire readable = ~i_code_protect | (addr_reg < swr_pkg::PROT_OPEN_TOP) | (addr_reg == swr_pkg::CAL_ADDR);
    wire [11:0] rd_word = id_hit ? id_mem[addr_reg[1:0]] : (readable ? i_pmem_rdata : 12'h0);
    wire [13:0] sh_in = {pdat, sh_reg[13:1]};
    wire [5:0] cmd_word = sh_in[13:8];
    wire cmd_done = prog_reg & pclk_rise & ~phase_reg & (bit_cnt_reg == swr_pkg::PG_CMD_LAST);
    wire data_done = prog_reg & pclk_rise & phase_reg & (bit_cnt_reg == swr_pkg::PG_DATA_LAST);
    wire load_done = data_done & ~rd_dir_reg;
    wire is_xfer = (cmd_word == swr_pkg::PG_LOAD) | (cmd_word == swr_pkg::PG_READ);

    // entry needs clock and data low as the programming voltage rises
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            prog_reg <= 1'b0;
        end else if (vpp_rise & ~sync2_reg[1] & ~pdat) begin
            prog_reg <= 1'b1;
        end else if (~sync2_reg[7]) begin
            prog_reg <= 1'b0;
        end
    end

    // serial shifter, address counter and write strobes
    always_ff @(posedge i_core_clk) begin
        if (i_reset | ~prog_reg) begin
            phase_reg <= 1'b0;
            rd_dir_reg <= 1'b0;
            bit_cnt_reg <= 5'h0;
            sh_reg <= 14'h0;
            addr_reg <= swr_pkg::PG_ADDR_RESET;
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
            we_reg <= 1'b0;
            wdata_reg <= 12'h0;
        end else begin
            we_reg <= load_done & ~id_hit;
            if (cmd_done) begin
                bit_cnt_reg <= 5'h0;
                phase_reg <= is_xfer;
                rd_dir_reg <= cmd_word == swr_pkg::PG_READ;
                oe_reg <= cmd_word == swr_pkg::PG_READ;
                sh_reg <= {1'b0, rd_word, 1'b0};
                dout_reg <= 1'b0;
                if (cmd_word == swr_pkg::PG_INC) begin
                    addr_reg <= addr_reg + 11'h1;
                end
            end else if (prog_reg & pclk_rise) begin
                bit_cnt_reg <= data_done ? 5'h0 : bit_cnt_reg + 5'h1;
                phase_reg <= phase_reg & ~data_done;
                oe_reg <= oe_reg & ~data_done;
                sh_reg <= (rd_dir_reg & phase_reg) ? {1'b0, sh_reg[13:1]} : sh_in; // commands always shift in
                dout_reg <= sh_reg[1];
                if (load_done) begin
                    wdata_reg <= sh_reg[13:2];
                end
            end
        end
    end

    // id words live only behind the programming port
    always_ff @(posedge i_core_clk) begin
        if (load_done & id_hit) begin
            id_mem[addr_reg[1:0]] <= sh_reg[13:2];
        end
    end

    // ==========================================================
    // outputs, all straight from flops; port hold tracks sleep
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_device_reset = state_reg[2];
    assign o_port_hold = state_reg[1];
    assign o_osc_drive_en = osc_en_reg;
    assign o_prog_mode = prog_reg;
    assign o_prog_data_out = dout_reg;
    assign o_prog_data_oe = oe_reg;
    assign o_pmem_addr = addr_reg;
    assign o_pmem_wdata = wdata_reg;
    assign o_pmem_we = we_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    chk_awake_wdog_flags: assert property (ev_wdog & ~ev_mclear & ~asleep |=>
        !timeout_flag_n_reg && powerdown_flag_n_reg == $past(powerdown_flag_n_reg) && !port_wake_flag_reg)
        else $error("awake watchdog flags wrong");
    chk_sleep_mclear_flags: assert property (asleep & ev_mclear |=>
        timeout_flag_n_reg && !powerdown_flag_n_reg && !comparator_wake_flag_reg)
        else $error("master clear wake flags wrong");
    chk_awake_mclear_keep: assert property (ev_mclear & ~asleep |=> $stable(timeout_flag_n_reg)
        && $stable(powerdown_flag_n_reg)) else $error("master clear changed flags");
    chk_pin_wake_flags: assert property (ev_pin & ~ev_mclear & ~ev_wdog |=>
        port_wake_flag_reg && !comparator_wake_flag_reg && !powerdown_flag_n_reg ##1 o_device_reset)
        else $error("pin wake wrong");
    chk_cmp_wake_flags: assert property (ev_cmp & ~ev_pin & ~ev_mclear & ~ev_wdog |=>
        comparator_wake_flag_reg && !port_wake_flag_reg && timeout_flag_n_reg) else $error("cmp wake wrong");
    chk_powerup_flags: assert property (@(posedge i_core_clk) disable iff (1'b0) i_reset |=>
        timeout_flag_n_reg && powerdown_flag_n_reg && !port_wake_flag_reg) else $error("power-up flags wrong");
    chk_sleep_wdog_flags: assert property (asleep & ev_wdog & ~ev_mclear |=>
        !timeout_flag_n_reg && !powerdown_flag_n_reg) else $error("watchdog wake flags wrong");
    chk_sleep_entry: assert property (sleep_go & ~reset_trig & ~prog_reg |=> o_port_hold && !o_osc_drive_en
        && watchdog_counter_reg == 20'h0 && !powerdown_flag_n_reg) else $error("sleep entry wrong");
    chk_stale_pin_wake: assert property (sleep_go & port_mis & ~reset_trig & ~prog_reg ##1 port_mis
        |=> o_device_reset) else $error("stale mismatch did not wake");
    chk_wake_clears_wdog: assert property (asleep & reset_trig |=> watchdog_counter_reg == 20'h0)
        else $error("watchdog not cleared on wake");
    chk_prog_entry: assert property (vpp_rise & ~sync2_reg[1] & ~pdat |=> o_prog_mode ##1 o_device_reset)
        else $error("program mode not entered");

    cov_pin_wake: cover property (asleep ##1 ev_pin);
    cov_cmp_wake: cover property (asleep ##1 ev_cmp);
    cov_wdog_wake: cover property (asleep & ev_wdog);
    cov_read_cmd: cover property (cmd_done & rd_dir_reg == 1'b0 ##1 rd_dir_reg);
endmodule : swr_sleep_wake_reset
`default_nettype wire

/* File: logic/swr_pkg.sv */
// package: register map, field positions, reset values and timing of the sleep/wake/reset block
package swr_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_PORT = 8'h0c;
    localparam logic [7:0] ADDR_CMP = 8'h10;
    localparam logic [7:0] ADDR_STATE = 8'h14;
    // ==========================================================
    // field positions and reset values
    localparam int ST_PORT_WAKE = 7;
    localparam int ST_CMP_WAKE = 6;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_PWRDN = 3;
    localparam int CTL_WDOG_EN = 0;
    localparam int CTL_PORT_WEN = 1;
    localparam int CTL_CMP_WEN = 2;
    localparam int CMD_SLEEP = 0;
    localparam int CMD_CLR_WDOG = 1;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam logic [7:0] SYNC_RESET = 8'h40;
    // ==========================================================
    // timing: reset stretch rounds up, watchdog period rounds down
    localparam int CLK_MHZ = 25;
    localparam int DRT_NS = 10000;
    localparam int DRT_CYC = (DRT_NS * CLK_MHZ + 999) / 1000;
    localparam int WDOG_NS = 18000000;
    localparam int WDOG_CYC = WDOG_NS / 1000 * CLK_MHZ;
    // ==========================================================
    // serial programming framing and address space
    localparam logic [5:0] PG_LOAD = 6'h02;
    localparam logic [5:0] PG_READ = 6'h04;
    localparam logic [5:0] PG_INC = 6'h06;
    localparam logic [4:0] PG_CMD_LAST = 5'h05;
    localparam logic [4:0] PG_DATA_LAST = 5'h0d;
    localparam logic [10:0] PG_ADDR_RESET = 11'h000;
    localparam logic [10:0] PROT_OPEN_TOP = 11'h040;
    localparam logic [10:0] CAL_ADDR = 11'h3ff;
    localparam logic [10:0] ID_BASE = 11'h400;
    // ==========================================================
    typedef enum logic [2:0] {
        SWR_RUN = 3'b001,
        SWR_SLEEP = 3'b010,
        SWR_RST = 3'b100
    } swr_state_t;
endpackage : swr_pkg

/* File: sim/swr_pmem_model.sv */
// partner model: program memory behind the programming port
`timescale 1ns/1ps
`default_nettype none
module swr_pmem_model (
    input wire logic i_core_clk,
    input wire logic [10:0] i_pmem_addr,
    input wire logic [11:0] i_pmem_wdata,
    input wire logic i_pmem_we,
    output logic [11:0] o_pmem_rdata
);
    // ========
    // word store, preset to its own address so reads are traceable
    logic [11:0] mem_reg [0:2047];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem_reg[i] = 12'(i);
        end
    end
    always @(posedge i_core_clk) begin
        if (i_pmem_we) begin
            mem_reg[i_pmem_addr] <= i_pmem_wdata;
        end
    end
    assign o_pmem_rdata = mem_reg[i_pmem_addr]; // combinational, as the port expects
endmodule : swr_pmem_model
`default_nettype wire

/* File: sim/swr_sleep_wake_reset_tb_top.sv */
// bench: wake sources, reset-cause flags and sleep behaviour
`timescale 1ns/1ps
`default_nettype none
module swr_sleep_wake_reset_tb_top;
    typedef struct {logic [31:0] ctrl; bit slp; int act; logic [31:0] exp;} swr_row_t;
    // ========
    // act: 0 watchdog, 1 master clear, 2 pin, 3 comparator
    swr_row_t rows [6] = '{
        '{32'h0, 1'b0, 1, 32'h18},
        '{32'h1, 1'b0, 0, 32'h08},
        '{32'h0, 1'b1, 1, 32'h10},
        '{32'h1, 1'b1, 0, 32'h00},
        '{32'h2, 1'b1, 2, 32'h90},
        '{32'h4, 1'b1, 3, 32'h50}};
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, master_clear_pin_n = 1, vpp = 0, prot = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] pins = 4'h0;
    logic [11:0] word;
    logic [1:0] cmp = 2'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, dev_rst, osc_en, hold, pmode, pdo, poe, we;
    wire logic [10:0] addr;
    wire logic [11:0] wdata, mdata;
    wire logic [3:0] pin_lvl = {pins[3:1], poe ? pdo : pins[0]}; // data pin shared
    int num_errors = 0, num_checks = 0;
    swr_sleep_wake_reset #(.WDOG_CYCLES(200)) u_swr_sleep_wake_reset (.i_core_clk(clk), .i_reset(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_wake_pins(pin_lvl),
        .i_comparator_outputs(cmp), .i_master_clear_pin_n(master_clear_pin_n), .i_vpp_high(vpp),
        .i_code_protect(prot), .i_pmem_rdata(mdata), .o_device_reset(dev_rst), .o_osc_drive_en(osc_en),
        .o_port_hold(hold), .o_prog_mode(pmode), .o_prog_data_out(pdo), .o_prog_data_oe(poe),
        .o_pmem_addr(addr), .o_pmem_wdata(wdata), .o_pmem_we(we));
    swr_pmem_model u_swr_pmem_model (.i_core_clk(clk), .i_pmem_addr(addr), .i_pmem_wdata(wdata),
        .i_pmem_we(we), .o_pmem_rdata(mdata));
    always #20 clk = ~clk;
    // ========
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // apb transfer; data taken at the pready edge, released after it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wait_lvl(input logic v, input int n);
        for (int i = 0; i < n && dev_rst !== v; i++) @(negedge clk);
        chk("device_reset", dev_rst, v);
    endtask : wait_lvl
    task automatic go_sleep;
        apb(1, swr_pkg::ADDR_CMD, 32'h1);
        repeat (2) @(negedge clk);
        chk("port_hold", hold, 1);
        chk("osc_drive", osc_en, 0);
    endtask : go_sleep
    task automatic do_act(input int a);
        @(posedge clk);
        case (a)
            1: begin
                master_clear_pin_n <= 1'b0;
                repeat (6) @(posedge clk);
                master_clear_pin_n <= 1'b1;
            end
            2: pins[2] <= ~pins[2];
            3: cmp[0] <= ~cmp[0];
            default: ;
        endcase
    endtask : do_act
    // programmer: data moves with the clock fall, 4 core cycles per clock level
    task automatic pbit(input logic b);
        pins[0] <= b;
        pins[1] <= 1'b0;
        repeat (4) @(posedge clk);
        pins[1] <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : pbit
    task automatic pcmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) begin
            pbit(c[i]);
        end
    endtask : pcmd
    task automatic pload(input logic [11:0] w);
        pcmd(swr_pkg::PG_LOAD);
        pbit(1'b0);
        for (int i = 0; i < 12; i++) begin
            pbit(w[i]);
        end
        pbit(1'b0);
    endtask : pload
    // word bit i stands on the data pin after data clock i+1
    task automatic pread(output logic [11:0] w);
        pcmd(swr_pkg::PG_READ);
        for (int i = 0; i < 14; i++) begin
            pbit(1'b0);
            if (i == 0) chk("data_oe", poe, 1);
            if (i < 12) w[i] = pdo;
        end
        chk("data_oe", poe, 0);
    endtask : pread
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // ========
    initial begin
        repeat (70000) @(posedge clk);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(0, swr_pkg::ADDR_STATUS, 0);
        chk("status", rd, 32'h18);
        apb(0, swr_pkg::ADDR_CTRL, 0);
        chk("ctrl", rd, 32'h1);
        wait_lvl(0, 400);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1, swr_pkg::ADDR_CTRL, rows[i].ctrl);
            apb(0, swr_pkg::ADDR_PORT, 0);
            apb(0, swr_pkg::ADDR_CMP, 0);
            if (rows[i].slp) go_sleep();
            do_act(rows[i].act);
            wait_lvl(1, 1000);
            wait_lvl(0, 1000);
            apb(0, swr_pkg::ADDR_STATUS, 0);
            chk("status", rd, rows[i].exp);
            $display("test row %0d done", i);
        end
        // disabled wake sources must not end sleep
        apb(1, swr_pkg::ADDR_CTRL, 0);
        apb(0, swr_pkg::ADDR_PORT, 0);
        apb(0, swr_pkg::ADDR_CMP, 0);
        go_sleep();
        @(posedge clk);
        pins[3] <= ~pins[3];
        cmp[1] <= ~cmp[1];
        repeat (30) @(negedge clk);
        chk("device_reset", dev_rst, 0);
        do_act(1);
        wait_lvl(1, 1000);
        wait_lvl(0, 1000);
        apb(0, swr_pkg::ADDR_STATUS, 0);
        chk("status", rd, 32'h10);
        $display("test disabled wake done");
        // stale pin mismatch wakes at once
        apb(1, swr_pkg::ADDR_CTRL, 32'h2);
        apb(1, swr_pkg::ADDR_CMD, 32'h1);
        wait_lvl(1, 20);
        wait_lvl(0, 1000);
        apb(0, swr_pkg::ADDR_STATUS, 0);
        chk("status", rd, 32'h90);
        // clear commands keep an enabled watchdog from firing
        apb(1, swr_pkg::ADDR_CTRL, 32'h1);
        repeat (3) begin
            repeat (150) @(posedge clk);
            apb(1, swr_pkg::ADDR_CMD, 32'h2);
        end
        @(negedge clk);
        chk("device_reset", dev_rst, 0);
        apb(0, 8'h3c, 0);
        chk("pslverr", err, 1);
        chk("prdata", rd, 0);
        vpp <= 1'b1; // clock and data pins held low
        repeat (10) @(negedge clk);
        chk("prog_mode", pmode, 1);
        apb(0, swr_pkg::ADDR_STATE, 0);
        chk("state", rd, 32'h5);
        $display("test misc done");
        pload(12'h5a3);
        chk("pmem_wdata", wdata, 32'h5a3);
        pread(word);
        chk("pmem_word", word, 32'h5a3);
        pcmd(swr_pkg::PG_INC);
        chk("pmem_addr", addr, 32'h1);
        prot <= 1'b1;
        for (int i = 0; i < 63; i++) begin
            pcmd(swr_pkg::PG_INC);
        end
        pread(word);
        chk("protected", word, 32'h0);
        prot <= 1'b0;
        pread(word);
        chk("open", word, 32'h40);
        for (int i = 0; i < 959; i++) begin
            pcmd(swr_pkg::PG_INC);
        end
        prot <= 1'b1;
        pread(word);
        chk("calibration", word, 32'h3ff);
        pcmd(swr_pkg::PG_INC);
        pload(12'h00a); // upper 8 bits zero
        pread(word);
        chk("id_word", word, 32'h00a);
        chk("pmem_at_id", u_swr_pmem_model.mem_reg[1024], 32'h400);
        $display("test programming done");
        close_out();
    end
endmodule : swr_sleep_wake_reset_tb_top
`default_nettype wire
